/* logic/seq_core.sv */
// Program sequencer core with program memory, data map and APB slave
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
// Summary of operation
// - Four phases per instruction cycle, one per system clock.
// - Prefetch overlaps execute; program counter changes cost a dummy cycle.
// - Program counter is twelve bits wide.
// - Each fetch advances the program counter by one.
// - A taken skip drops the prefetched word and inserts a dummy cycle.
// - Low counter byte at 06H; a write jumps within the current page.
// - Reset clears the program counter to zero.
// - Enabled external event with stack room pushes and branches to 004H.
// - Edge select port bit picks the active external edge.
// - Select high means rising edge, select low means falling edge.
// - Enabled timer overflow with stack room pushes and branches to 008H.
// - Acknowledge clears the source flag and the global enable.
// - Program memory is 3072 words of 16 bits, fetched or table read.
// - Table address uses current page or fixed last page with pointer byte.
// - Table low byte goes to destination; bits 14:8 to read-only high byte, its top bit zero.
// - Table pointer register at 07H supplies the low table address.
// - A table read takes two instruction cycles.
// - Six-entry hidden stack, pushed by call or interrupt, popped by returns.
// - Reset points the stack index at the top.
// - Unimplemented data addresses below 60H read as zero.
// - Data RAM from 60H to FFH, every bit writable.
// - Addresses 00H and 02H go through pointers at 01H and 03H.
// - Indirect access selecting 00H or 02H reads zero, writes ignored.
// - Accumulator is mapped at 05H and carries memory moves.
module seq_core
    import seq_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_irq_pin,
    input wire logic edge_select_port_bit,
    input wire logic timer_overflow,
    input wire ctrl_t ctrl,
    output exec_t exec,
    output logic [1:0] phase
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [WORD_W-1:0] prog_mem [PROG_DEPTH];
    logic [7:0] ram [RAM_WORDS];
    logic [PC_W-1:0] pc, next_pc;
    logic [1:0] next_phase;
    exec_t cur, next_cur;
    logic [7:0] acc, next_acc, ptr0, next_ptr0, ptr1, next_ptr1;
    logic [7:0] table_pointer, next_table_pointer, table_high_byte, next_table_high_byte, pcl_val, next_pcl_val;
    logic pcl_pend, next_pcl_pend;
    logic glob_en, next_glob_en, ext_en, next_ext_en, tmr_en, next_tmr_en;
    logic ext_flag, next_ext_flag, tmr_flag, next_tmr_flag;
    logic [11:0] load_addr, next_load_addr;
    logic ack, next_ack, slverr_q, next_slverr_q;
    logic [31:0] prdata_q, next_prdata_q;
    logic sync1, sync2, sync3, pin_stable, next_pin_stable;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencing signals
    logic cycle_end, irq_ready, take_irq, ack_ext, ack_tmr, fetch_normal;
    logic stk_push, stk_pop, stk_full, tab_we, ext_edge;
    logic [PC_W-1:0] stk_top, taddr;
    logic [WORD_W-1:0] fetch_word, tword;
    op_t act;

    return_stack #(.DEPTH(STACK_DEPTH), .WIDTH(PC_W)) u_stack (
        .clock(clock),
        .srst(srst),
        .push(stk_push),
        .pop(stk_pop),
        .push_data(pc),
        .top_data(stk_top),
        .full(stk_full)
    );

    assign cycle_end = (phase == PHASE_LAST);
    assign act = cur.valid ? ctrl.op : OP_NONE;
    assign fetch_word = (int'(pc) < PROG_DEPTH) ? prog_mem[pc] : '0;
    assign taddr = (act == OP_TAB_LAST) ? {LAST_PAGE, table_pointer} : {pc[11:8], table_pointer};
    assign tword = (int'(taddr) < PROG_DEPTH) ? prog_mem[taddr] : '0;
    assign tab_we = cycle_end && (act == OP_TAB_CUR || act == OP_TAB_LAST);
    assign irq_ready = glob_en && !stk_full && ((ext_en && ext_flag) || (tmr_en && tmr_flag));
    assign take_irq = cycle_end && irq_ready && act == OP_NONE && !pcl_pend;
    assign ack_ext = take_irq && ext_en && ext_flag;
    assign ack_tmr = take_irq && !ack_ext;

    always_comb begin
        next_phase = 2'(phase + 2'h1);
        next_pc = pc;
        next_cur = cur;
        stk_push = 1'b0;
        stk_pop = 1'b0;
        fetch_normal = 1'b0;
        if (cycle_end) begin
            next_cur = '0;
            if (take_irq) begin
                stk_push = 1'b1;
                next_pc = ack_ext ? VEC_EXT : VEC_TIMER;
            end else if (pcl_pend) begin
                next_pc = {pc[11:8], pcl_val};
            end else begin
                case (act)
                    OP_JUMP: next_pc = ctrl.target;
                    OP_CALL: begin
                        stk_push = 1'b1;
                        next_pc = ctrl.target;
                    end
                    OP_RET, OP_RETURN_ENABLE_IRQ: begin
                        stk_pop = 1'b1;
                        next_pc = stk_top;
                    end
                    OP_SKIP: next_pc = 12'(pc + 12'h1);
                    OP_TAB_CUR, OP_TAB_LAST: next_pc = pc;
                    default: begin
                        fetch_normal = 1'b1;
                        next_cur = '{word: fetch_word, addr: pc, valid: 1'b1};
                        next_pc = 12'(pc + 12'h1);
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External pin edge detection
    assign ext_edge = (sync2 == sync3) && (sync3 != pin_stable) &&
                      (edge_select_port_bit ? sync3 : !sync3);
    assign next_pin_stable = (sync2 == sync3) ? sync3 : pin_stable;

    ////////////////////////////////////////////////////////////////////////////
    // Data map access
    logic [9:0] idx;
    logic access, bus_wr, map_hit, wr_en, wr_bad;
    logic [7:0] rd_ea, wr_ea, wr_data, rd_byte, irq_byte;
    logic [31:0] rd_value;

    assign idx = paddr[11:2];
    assign access = psel && penable;
    assign map_hit = idx < IDX_MAP_LIMIT || idx == IDX_LOAD_ADDR || idx == IDX_LOAD_DATA;
    assign bus_wr = access && ack && pwrite && !slverr_q;

    function automatic logic [8:0] resolve(input logic [7:0] a, input logic [7:0] p0,
                                           input logic [7:0] p1);
        logic [7:0] ea;
        ea = a;
        if (a == ADR_IND0) begin
            ea = p0;
        end else if (a == ADR_IND1) begin
            ea = p1;
        end
        return {(a == ADR_IND0 || a == ADR_IND1) && (ea == ADR_IND0 || ea == ADR_IND1), ea};
    endfunction

    always_comb begin
        irq_byte = '0;
        irq_byte[IRQ_GLOBAL_BIT] = glob_en;
        irq_byte[IRQ_EXT_EN_BIT] = ext_en;
        irq_byte[IRQ_TMR_EN_BIT] = tmr_en;
        irq_byte[IRQ_EXT_FLAG_BIT] = ext_flag;
        irq_byte[IRQ_TMR_FLAG_BIT] = tmr_flag;
    end

    always_comb begin
        logic [8:0] r;
        r = resolve(idx[7:0], ptr0, ptr1);
        rd_ea = r[7:0];
        rd_byte = BYTE_RESET;
        if (r[8]) begin
            rd_byte = BYTE_RESET;
        end else if (rd_ea >= ADR_RAM_BASE) begin
            rd_byte = ram[8'(rd_ea - ADR_RAM_BASE)];
        end else if (rd_ea == ADR_PTR0) begin
            rd_byte = ptr0;
        end else if (rd_ea == ADR_PTR1) begin
            rd_byte = ptr1;
        end else if (rd_ea == ADR_ACC) begin
            rd_byte = acc;
        end else if (rd_ea == ADR_PCL) begin
            rd_byte = pc[7:0];
        end else if (rd_ea == ADR_TABLE_POINTER) begin
            rd_byte = table_pointer;
        end else if (rd_ea == ADR_TABLE_HIGH_BYTE) begin
            rd_byte = table_high_byte;
        end else if (rd_ea == ADR_IRQ_CTRL) begin
            rd_byte = irq_byte;
        end
        if (idx == IDX_LOAD_ADDR) begin
            rd_value = {20'h00000, load_addr};
        end else if (idx == IDX_LOAD_DATA) begin
            rd_value = (int'(load_addr) < PROG_DEPTH) ? {16'h0000, prog_mem[load_addr]} : '0;
        end else if (idx < IDX_MAP_LIMIT) begin
            rd_value = {24'h000000, rd_byte};
        end else begin
            rd_value = '0;
        end
    end

    always_comb begin
        logic [8:0] r;
        r = '0;
        wr_en = 1'b0;
        wr_data = '0;
        if (tab_we) begin
            wr_en = 1'b1;
            r = resolve(ctrl.dest, ptr0, ptr1);
            wr_data = tword[7:0];
        end else if (bus_wr && idx < IDX_MAP_LIMIT) begin
            wr_en = 1'b1;
            r = resolve(idx[7:0], ptr0, ptr1);
            wr_data = pwdata[7:0];
        end
        wr_bad = r[8];
        wr_ea = r[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register next values
    always_comb begin
        logic wr_ok;
        wr_ok = wr_en && !wr_bad;
        next_acc = (wr_ok && wr_ea == ADR_ACC) ? wr_data : acc;
        next_ptr0 = (wr_ok && wr_ea == ADR_PTR0) ? wr_data : ptr0;
        next_ptr1 = (wr_ok && wr_ea == ADR_PTR1) ? wr_data : ptr1;
        next_table_pointer = (wr_ok && wr_ea == ADR_TABLE_POINTER) ? wr_data : table_pointer;
        next_table_high_byte = tab_we ? {1'b0, tword[14:8]} : table_high_byte;
        next_pcl_val = (wr_ok && wr_ea == ADR_PCL) ? wr_data : pcl_val;
        next_pcl_pend = (pcl_pend && !cycle_end) || (wr_ok && wr_ea == ADR_PCL);
        next_glob_en = glob_en;
        next_ext_en = ext_en;
        next_tmr_en = tmr_en;
        next_ext_flag = ext_flag;
        next_tmr_flag = tmr_flag;
        if (wr_ok && wr_ea == ADR_IRQ_CTRL) begin
            next_glob_en = wr_data[IRQ_GLOBAL_BIT];
            next_ext_en = wr_data[IRQ_EXT_EN_BIT];
            next_tmr_en = wr_data[IRQ_TMR_EN_BIT];
            next_ext_flag = wr_data[IRQ_EXT_FLAG_BIT];
            next_tmr_flag = wr_data[IRQ_TMR_FLAG_BIT];
        end
        if (cycle_end && act == OP_RETURN_ENABLE_IRQ) begin
            next_glob_en = 1'b1;
        end
        if (take_irq) begin
            next_glob_en = 1'b0;
            next_ext_flag = ack_ext ? 1'b0 : next_ext_flag;
            next_tmr_flag = ack_tmr ? 1'b0 : next_tmr_flag;
        end
        next_ext_flag = next_ext_flag || ext_edge;
        next_tmr_flag = next_tmr_flag || timer_overflow;
        next_load_addr = load_addr;
        if (bus_wr && idx == IDX_LOAD_ADDR) begin
            next_load_addr = pwdata[11:0];
        end else if (bus_wr && idx == IDX_LOAD_DATA) begin
            next_load_addr = 12'(load_addr + 12'h1);
        end
        next_ack = access && !ack && phase != PHASE_PRE_LAST;
        next_prdata_q = (access && !ack) ? rd_value : prdata_q;
        next_slverr_q = (access && !ack) ? !map_hit : slverr_q;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            phase <= PHASE_RESET;
            pc <= PC_RESET;
            cur <= '0;
            acc <= BYTE_RESET;
            ptr0 <= BYTE_RESET;
            ptr1 <= BYTE_RESET;
            table_pointer <= BYTE_RESET;
            table_high_byte <= BYTE_RESET;
            pcl_val <= BYTE_RESET;
            pcl_pend <= 1'b0;
            glob_en <= 1'b0;
            ext_en <= 1'b0;
            tmr_en <= 1'b0;
            ext_flag <= 1'b0;
            tmr_flag <= 1'b0;
            load_addr <= '0;
            ack <= 1'b0;
            slverr_q <= 1'b0;
            prdata_q <= '0;
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            pin_stable <= 1'b0;
        end else begin
            phase <= next_phase;
            pc <= next_pc;
            cur <= next_cur;
            acc <= next_acc;
            ptr0 <= next_ptr0;
            ptr1 <= next_ptr1;
            table_pointer <= next_table_pointer;
            table_high_byte <= next_table_high_byte;
            pcl_val <= next_pcl_val;
            pcl_pend <= next_pcl_pend;
            glob_en <= next_glob_en;
            ext_en <= next_ext_en;
            tmr_en <= next_tmr_en;
            ext_flag <= next_ext_flag;
            tmr_flag <= next_tmr_flag;
            load_addr <= next_load_addr;
            ack <= next_ack;
            slverr_q <= next_slverr_q;
            prdata_q <= next_prdata_q;
            sync1 <= ext_irq_pin;
            sync2 <= sync1;
            sync3 <= sync2;
            pin_stable <= next_pin_stable;
        end
    end

    // Memories
    always_ff @(posedge clock) begin
        if (wr_en && !wr_bad && wr_ea >= ADR_RAM_BASE) begin
            ram[8'(wr_ea - ADR_RAM_BASE)] <= wr_data;
        end
        if (bus_wr && idx == IDX_LOAD_DATA && int'(load_addr) < PROG_DEPTH) begin
            prog_mem[load_addr] <= pwdata[15:0];
        end
    end

    assign exec = cur;
    assign prdata = prdata_q;
    assign pready = ack;
    assign pslverr = ack && slverr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence phase_walk;
        phase == 2'h1 ##1 phase == 2'h2 ##1 phase == 2'h3 ##1 phase == 2'h0;
    endsequence

    chk_phase_cycle: assert property (phase == 2'h0 |=> phase_walk)
        else $error("phase sequence broken");
    chk_jump_dummy: assert property (cycle_end && !pcl_pend && act == OP_JUMP |=>
        pc == $past(ctrl.target) && !cur.valid ##1 ($stable(pc) && !cur.valid) [*3])
        else $error("jump without dummy cycle");
    chk_fetch_step: assert property (fetch_normal |=>
        pc == 12'($past(pc) + 12'h1) && cur.addr == $past(pc) && cur.valid)
        else $error("fetch did not advance");
    chk_skip_drop: assert property (cycle_end && !pcl_pend && act == OP_SKIP |=>
        pc == 12'($past(pc) + 12'h1) && !cur.valid)
        else $error("skip kept prefetch");
    chk_pcl_jump: assert property (cycle_end && pcl_pend && !take_irq |=>
        pc[11:8] == $past(pc[11:8]) && pc[7:0] == $past(pcl_val))
        else $error("low byte jump wrong");
    chk_reset_start: assert property ($past(srst) |-> pc == VEC_RESET && !cur.valid)
        else $error("reset address wrong");
    chk_ext_vector: assert property (ack_ext |=> pc == VEC_EXT && !glob_en)
        else $error("external vector wrong");
    chk_edge_flag: assert property (ext_edge |=> ext_flag)
        else $error("edge not flagged");
    chk_tmr_vector: assert property (ack_tmr |=> pc == VEC_TIMER && !cur.valid)
        else $error("timer vector wrong");
    chk_ack_mask: assert property (take_irq |=> !glob_en ##1 !take_irq)
        else $error("acknowledge left enable set");
    chk_table_two: assert property (tab_we |=> pc == $past(pc) && !cur.valid &&
        table_high_byte == {1'b0, $past(tword[14:8])})
        else $error("table read timing wrong");

endmodule

/* logic/seq_pkg.sv */
// Shared constants and types for the program sequencer core
package seq_pkg;

    localparam int PC_W = 12;
    localparam int WORD_W = 16;
    localparam int PROG_DEPTH = 3072;
    localparam int RAM_WORDS = 160;
    localparam int STACK_DEPTH = 6;

    // Data memory map, register indices (byte address is four times the index)
    localparam logic [7:0] ADR_IND0 = 8'h00;
    localparam logic [7:0] ADR_PTR0 = 8'h01;
    localparam logic [7:0] ADR_IND1 = 8'h02;
    localparam logic [7:0] ADR_PTR1 = 8'h03;
    localparam logic [7:0] ADR_ACC = 8'h05;
    localparam logic [7:0] ADR_PCL = 8'h06;
    localparam logic [7:0] ADR_TABLE_POINTER = 8'h07;
    localparam logic [7:0] ADR_TABLE_HIGH_BYTE = 8'h08;
    localparam logic [7:0] ADR_IRQ_CTRL = 8'h0b;
    localparam logic [7:0] ADR_RAM_BASE = 8'h60;
    localparam logic [9:0] IDX_MAP_LIMIT = 10'h100;
    localparam logic [9:0] IDX_LOAD_ADDR = 10'h100;
    localparam logic [9:0] IDX_LOAD_DATA = 10'h101;

    // Interrupt control bit positions
    localparam int IRQ_GLOBAL_BIT = 0;
    localparam int IRQ_EXT_EN_BIT = 1;
    localparam int IRQ_TMR_EN_BIT = 2;
    localparam int IRQ_EXT_FLAG_BIT = 4;
    localparam int IRQ_TMR_FLAG_BIT = 5;

    // Vectors and table page
    localparam logic [11:0] VEC_RESET = 12'h000;
    localparam logic [11:0] VEC_EXT = 12'h004;
    localparam logic [11:0] VEC_TIMER = 12'h008;
    localparam logic [3:0] LAST_PAGE = 4'hb;

    // Phases and reset values
    localparam logic [1:0] PHASE_RESET = 2'h0;
    localparam logic [1:0] PHASE_PRE_LAST = 2'h2;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [11:0] PC_RESET = VEC_RESET;

    typedef enum logic [2:0] {
        OP_NONE, OP_JUMP, OP_CALL, OP_RET, OP_RETURN_ENABLE_IRQ, OP_SKIP, OP_TAB_CUR, OP_TAB_LAST
    } op_t;

    typedef struct packed {
        op_t op;
        logic [11:0] target;
        logic [7:0] dest;
    } ctrl_t;

    typedef struct packed {
        logic [15:0] word;
        logic [11:0] addr;
        logic valid;
    } exec_t;

endpackage

/* logic/return_stack.sv */
// Hidden return address stack, shift organised
`timescale 1ns/100ps
module return_stack #(
    parameter int DEPTH = 6,
    parameter int WIDTH = 12
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic push,
    input wire logic pop,
    input wire logic [WIDTH-1:0] push_data,
    output logic [WIDTH-1:0] top_data,
    output logic full
);
    localparam int LVL_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] entry [DEPTH];
    logic [LVL_W-1:0] level;
    logic [LVL_W-1:0] next_level;

    always_comb begin
        next_level = level;
        if (push && level != LVL_W'(DEPTH)) begin
            next_level = LVL_W'(level + 1'b1);
        end else if (pop && level != '0) begin
            next_level = LVL_W'(level - 1'b1);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            level <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                entry[i] <= '0;
            end
        end else begin
            level <= next_level;
            if (push) begin
                entry[0] <= push_data;
                for (int i = 1; i < DEPTH; i++) begin
                    entry[i] <= entry[i-1];
                end
            end else if (pop) begin
                for (int i = 0; i < DEPTH - 1; i++) begin
                    entry[i] <= entry[i+1];
                end
                entry[DEPTH-1] <= '0;
            end
        end
    end

    assign top_data = entry[0];
    assign full = (level == LVL_W'(DEPTH));

endmodule

/* tb/mcu_program_sequencer_tb_top.sv */
// Self-checking bench for the program sequencer core
`timescale 1ns/100ps
module mcu_program_sequencer_tb_top;
    import seq_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ext_irq_pin = 1'b0;
    logic edge_select_port_bit = 1'b0;
    logic timer_overflow = 1'b0;
    ctrl_t ctrl = '0;
    exec_t exec;
    logic [1:0] phase;
    int miscompares = 0;
    int total_checks = 0;
    int ph_cnt = 0;
    int d;
    logic [1:0] ph_exp;
    logic [15:0] mem_model [int];
    logic [11:0] ret_q [$];
    logic [31:0] rd;
    logic err;
    logic [11:0] a;
    logic [9:0] map_idx [14] = '{10'h001, 10'h000, 10'h070, 10'h003, 10'h002, 10'h002,
        10'h040, 10'h040, 10'h005, 10'h005, 10'h0ff, 10'h0ff, 10'h003, 10'h002};
    logic [7:0] map_val [14] = '{8'h70, 8'ha5, 8'ha5, 8'h02, 8'h55, 8'h00, 8'hff, 8'h00,
        8'h3c, 8'h3c, 8'h81, 8'h81, 8'h70, 8'ha5};
    logic [13:0] map_wr = 14'b01010101011011;
    logic [3:0] ext_sel = 4'b0011;
    logic [3:0] ext_pin = 4'b0101;
    logic [3:0] ext_hit = 4'b1001;

    always #2 clock = ~clock;

    seq_core DUT (.clock(clock), .srst(srst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_irq_pin(ext_irq_pin),
        .edge_select_port_bit(edge_select_port_bit), .timer_overflow(timer_overflow),
        .ctrl(ctrl), .exec(exec), .phase(phase));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic apb(input logic [9:0] idx, input logic wr, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 40) chk(32'h0, 32'h1);
    endtask

    task automatic next_exec();
        int n;
        n = 0;
        d = 0;
        do begin
            @(negedge clock);
            n++;
            if (phase === 2'h0 && exec.valid !== 1'b1) d++;
        end while (!(phase === 2'h0 && exec.valid === 1'b1) && n < 200);
        a = exec.addr;
        if (n >= 200) chk(32'h0, 32'h1);
        if (mem_model.exists(int'(a))) chk(32'(exec.word), 32'(mem_model[int'(a)]));
    endtask

    task automatic step(input op_t op, input logic [11:0] tgt, input logic [7:0] dst,
        input logic [11:0] exp_a);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (!(phase === 2'h2 && exec.valid === 1'b1) && n < 200);
        if (n >= 200) chk(32'h0, 32'h1);
        @(posedge clock);
        ctrl <= '{op: op, target: tgt, dest: dst};
        @(posedge clock);
        ctrl <= '0;
        next_exec();
        chk(32'(a), 32'(exp_a));
        chk(32'(d), 32'h1);
    endtask

    task automatic load(input logic [11:0] base, input int cnt);
        logic [15:0] w;
        apb(10'h100, 1'b1, 16'(base));
        for (int i = 0; i < cnt; i++) begin
            w = 16'($urandom);
            mem_model[int'(base) + i] = w;
            apb(10'h101, 1'b1, w);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clock) begin
        if (ph_cnt > 2) chk(32'(phase), 32'(ph_exp));
        ph_exp = phase + 2'h1;
        ph_cnt = srst ? 0 : ph_cnt + 1;
    end

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h12e3c483));
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        load(12'h000, 64);
        load(12'h512, 1);
        load(12'hb12, 1);
        @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        next_exec();
        chk(32'(a), 32'h0);
        next_exec();
        chk(32'(a), 32'h1);
        chk(32'(d), 32'h0);
        $display("test reset_fetch done");
        step(OP_JUMP, 12'h020, 8'h00, 12'h020);
        step(OP_SKIP, 12'h000, 8'h00, 12'h022);
        for (int i = 0; i < 7; i++) begin
            ret_q.push_back(a + 12'h1);
            if (ret_q.size() > 6) void'(ret_q.pop_front());
            step(OP_CALL, 12'h010 + 12'(i * 4), 8'h00, 12'h010 + 12'(i * 4));
        end
        for (int i = 0; i < 6; i++) begin
            step(i[0] ? OP_RETURN_ENABLE_IRQ : OP_RET, 12'h000, 8'h00, ret_q.pop_back());
        end
        $display("test branch_stack done");
        step(OP_JUMP, 12'h5f0, 8'h00, 12'h5f0);
        apb(10'h006, 1'b1, 16'h0015);
        d = 0;
        repeat (3) if (d == 0) next_exec();
        chk(32'(a), 32'h515);
        apb(10'h007, 1'b1, 16'h0012);
        apb(10'h007, 1'b0, 16'h0000);
        chk(rd, 32'h12);
        next_exec();
        step(OP_TAB_CUR, 12'h000, 8'h60, a + 12'h1);
        step(OP_TAB_LAST, 12'h000, 8'h61, a + 12'h1);
        apb(10'h060, 1'b0, 16'h0000);
        chk(rd, 32'(mem_model[32'h512][7:0]));
        apb(10'h061, 1'b0, 16'h0000);
        chk(rd, 32'(mem_model[32'hb12][7:0]));
        apb(10'h008, 1'b1, 16'h00ff);
        apb(10'h008, 1'b0, 16'h0000);
        chk(rd, {25'h0, mem_model[32'hb12][14:8]});
        $display("test page_table done");
        for (int i = 0; i < 14; i++) begin
            apb(map_idx[i], map_wr[i], {8'h00, map_val[i]});
            if (!map_wr[i]) chk(rd, 32'(map_val[i]));
        end
        apb(10'h200, 1'b0, 16'h0000);
        chk(32'(err), 32'h1);
        $display("test data_map done");
        apb(10'h00b, 1'b1, 16'h0005);
        @(posedge clock);
        timer_overflow <= 1'b1;
        @(posedge clock);
        timer_overflow <= 1'b0;
        a = 12'h000;
        repeat (4) if (a != 12'h008) next_exec();
        chk(32'(a), 32'h8);
        apb(10'h00b, 1'b0, 16'h0000);
        chk(rd, 32'h4);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            edge_select_port_bit <= ext_sel[i];
            apb(10'h00b, 1'b1, 16'h0003);
            ext_irq_pin <= ext_pin[i];
            a = 12'h000;
            repeat (4) if (a != 12'h004) next_exec();
            chk(32'(a == 12'h004), 32'(ext_hit[i]));
            apb(10'h00b, 1'b0, 16'h0000);
            chk(rd, ext_hit[i] ? 32'h2 : 32'h3);
        end
        $display("test interrupts done");
        end_of_test();
    end
endmodule
